// File: rtl/decimal_subtract_and_multiply_unit.sv
// Purpose: decimal subtract with borrow and binary multiply unit behind APB
// Assumes: pclk 125 MHz, presetn async low, ce freezes every flop when low
// Notes: each command runs one cycle after its write; results in four words
//
// Functional notes
// - word subtract takes deducted value and borrow from 4-digit base
// - double subtract works on two-word 8-digit operands and result
// - a negative decimal result is left in ten's complement form
// - ten's complement is nine minus each digit, plus one
// - decimal ops set fault on any non-decimal source digit, else clear
// - borrow flag follows borrow out of the top digit
// - zero flag set when full-width result is zero, else cleared
// - carry clear operation forces borrow flag to zero
// - signed word multiply gives 32-bit product in two words
// - signed double multiply gives 64-bit product in four words
// - negative flag equals top bit of full-width product
// - unsigned word multiply gives double-width unsigned product
// - unsigned double multiply gives four-word unsigned product
`timescale 1ns/1ps
module decimal_subtract_and_multiply_unit
   import alu_pkg::*;
(
   // clock, reset and enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq
);

   // true when a word is all zero
   function automatic logic all_zero(input logic [63:0] v);
      all_zero = (v == 64'h0000_0000_0000_0000);
   endfunction

   // word forms keep only the low four digits, or sixteen bits; high half reads zero
   function automatic logic [31:0] keep_width(input logic dbl, input logic [31:0] v);
      keep_width = dbl ? v : {16'h0000, v[15:0]};
   endfunction

   // registers
   logic [15:0] a_lo_ff;
   logic [15:0] a_hi_ff;
   logic [15:0] b_lo_ff;
   logic [15:0] b_hi_ff;
   logic [11:0] op_ff;
   flags_t flags_ff;
   quad_t res_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   state_t state_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic irq_ff;

   // next values
   flags_t nxt_flags;
   quad_t nxt_res;
   state_t nxt_state;
   logic [IRQ_W-1:0] nxt_irq_stat;
   logic [31:0] nxt_prdata;

   // apb phase decode: the access cycle loads the answer, the ready cycle ends it
   wire access = psel & penable & ~pready_ff;
   wire done_xfer = psel & penable & pready_ff;
   wire wr_en = done_xfer & pwrite;

   // register selects; an address that hits none is refused
   wire sel_a_lo = (paddr == OFS_A_LO);
   wire sel_a_hi = (paddr == OFS_A_HI);
   wire sel_b_lo = (paddr == OFS_B_LO);
   wire sel_b_hi = (paddr == OFS_B_HI);
   wire sel_cmd = (paddr == OFS_CMD);
   wire sel_flags = (paddr == OFS_FLAGS);
   wire sel_res0 = (paddr == OFS_RES0);
   wire sel_res1 = (paddr == OFS_RES1);
   wire sel_res2 = (paddr == OFS_RES2);
   wire sel_res3 = (paddr == OFS_RES3);
   wire sel_istat = (paddr == OFS_IRQ_STAT);
   wire sel_imask = (paddr == OFS_IRQ_MASK);
   wire mapped = sel_a_lo | sel_a_hi | sel_b_lo | sel_b_hi | sel_cmd | sel_flags
                 | sel_res0 | sel_res1 | sel_res2 | sel_res3 | sel_istat | sel_imask;

   // command acceptance
   wire [11:0] cmd_code = pwdata[11:0];
   wire cmd_known = (cmd_code == OP_SUB_WORD) | (cmd_code == OP_SUB_DOUBLE)
                    | (cmd_code == OP_MUL_S_WORD) | (cmd_code == OP_MUL_S_DOUBLE)
                    | (cmd_code == OP_MUL_U_WORD) | (cmd_code == OP_MUL_U_DOUBLE)
                    | (cmd_code == OP_CARRY_CLEAR);
   wire idle = (state_ff == ST_IDLE);
   wire cmd_wr = wr_en & sel_cmd;
   wire cmd_take = cmd_wr & idle & cmd_known;
   wire cmd_reject = cmd_wr & ~(idle & cmd_known);
   wire exec = (state_ff == ST_EXEC);

   // operation decode of the latched code
   wire do_sub_w = (op_ff == OP_SUB_WORD);
   wire do_sub_d = (op_ff == OP_SUB_DOUBLE);
   wire do_mul_sw = (op_ff == OP_MUL_S_WORD);
   wire do_mul_sd = (op_ff == OP_MUL_S_DOUBLE);
   wire do_mul_uw = (op_ff == OP_MUL_U_WORD);
   wire do_mul_ud = (op_ff == OP_MUL_U_DOUBLE);
   wire do_clc = (op_ff == OP_CARRY_CLEAR);
   wire do_sub = do_sub_w | do_sub_d;
   wire do_mul = do_mul_sw | do_mul_sd | do_mul_uw | do_mul_ud;

   // the one cycle in which each kind of operation lands its results
   wire run_sub = exec & do_sub;
   wire run_mul = exec & do_mul;
   wire run_clc = exec & do_clc;

   // two-word operands, low word at the lower address
   wire [31:0] opnd_a = {a_hi_ff, a_lo_ff};
   wire [31:0] opnd_b = {b_hi_ff, b_lo_ff};

   // word ops see only the low word; high digits forced to zero
   wire [31:0] sub_a = keep_width(do_sub_d, opnd_a);
   wire [31:0] sub_b = keep_width(do_sub_d, opnd_b);

   // decimal subtract chain
   logic [31:0] sub_diff;
   logic sub_br_w;
   logic sub_br_d;
   logic sub_bad_w;
   logic sub_bad_d;

   bcd_sub_chain u_bcd_sub
   (
      .minuend(sub_a),
      .subtrahend(sub_b),
      .borrow_in(flags_ff.borrow),
      .diff(sub_diff),
      .borrow_word(sub_br_w),
      .borrow_double(sub_br_d),
      .bad_word(sub_bad_w),
      .bad_double(sub_bad_d)
   );

   // word subtract keeps four digits, double keeps eight
   wire [31:0] sub_res = keep_width(do_sub_d, sub_diff);
   wire sub_borrow = do_sub_d ? sub_br_d : sub_br_w;
   wire sub_bad = do_sub_d ? sub_bad_d : sub_bad_w;

   // operands widened to the product width first, so no product bit is lost;
   // signed forms copy the sign bit, unsigned forms pad with zero
   wire [31:0] mcand_ws = {{16{a_lo_ff[15]}}, a_lo_ff};
   wire [31:0] mplier_ws = {{16{b_lo_ff[15]}}, b_lo_ff};
   wire [31:0] mcand_wu = {16'h0000, a_lo_ff};
   wire [31:0] mplier_wu = {16'h0000, b_lo_ff};
   wire [63:0] mcand_ds = {{32{opnd_a[31]}}, opnd_a};
   wire [63:0] mplier_ds = {{32{opnd_b[31]}}, opnd_b};
   wire [63:0] mcand_du = {32'h0000_0000, opnd_a};
   wire [63:0] mplier_du = {32'h0000_0000, opnd_b};

   // multipliers; each keeps the low half of an equal-width product
   wire [31:0] prod_sw = 32'($signed(mcand_ws) * $signed(mplier_ws));
   wire [63:0] prod_sd = 64'($signed(mcand_ds) * $signed(mplier_ds));
   wire [31:0] prod_uw = 32'(mcand_wu * mplier_wu);
   wire [63:0] prod_ud = 64'(mcand_du * mplier_du);

   // select the full-width result of the running operation
   wire [63:0] mul_res = do_mul_sd ? prod_sd
                        : do_mul_ud ? prod_ud
                        : do_mul_sw ? {32'h0000_0000, prod_sw}
                        : {32'h0000_0000, prod_uw};
   wire mul_top = do_mul_sd ? prod_sd[63]
                 : do_mul_ud ? prod_ud[63]
                 : do_mul_sw ? prod_sw[31]
                 : prod_uw[31];

   // results and flags produced in the execute cycle
   always_comb
   begin
      nxt_res = res_ff;
      nxt_flags = flags_ff;
      if (wr_en & sel_flags)
      begin
         nxt_flags.borrow = pwdata[FLG_BORROW];
      end
      if (run_sub)
      begin
         nxt_res = {32'h0000_0000, sub_res};
         nxt_flags.fault = sub_bad;
         nxt_flags.borrow = sub_borrow;
         nxt_flags.zero = all_zero({32'h0000_0000, sub_res});
      end
      else if (run_mul)
      begin
         nxt_res = mul_res;
         nxt_flags.fault = 1'b0;
         nxt_flags.zero = all_zero(mul_res);
         nxt_flags.negative = mul_top;
      end
      else if (run_clc)
      begin
         nxt_flags.borrow = 1'b0;
      end
   end

   // sequencer: one execute cycle per accepted command
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:
         begin
            if (cmd_take)
            begin
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            nxt_state = ST_IDLE;
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // interrupt status: new events win over a write-one clear
   wire [IRQ_W-1:0] irq_evt = {cmd_reject, run_sub & sub_bad, exec};
   wire [IRQ_W-1:0] irq_clr = (wr_en & sel_istat) ? pwdata[IRQ_W-1:0] : RST_IRQ;
   assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;

   // level request: any status bit that the mask lets through
   wire irq_pending = |(irq_stat_ff & irq_mask_ff);

   // read data mux
   always_comb
   begin
      nxt_prdata = RST_RDATA;
      unique case (1'b1)
         sel_a_lo: nxt_prdata = {16'h0000, a_lo_ff};
         sel_a_hi: nxt_prdata = {16'h0000, a_hi_ff};
         sel_b_lo: nxt_prdata = {16'h0000, b_lo_ff};
         sel_b_hi: nxt_prdata = {16'h0000, b_hi_ff};
         sel_cmd: nxt_prdata = {20'h0_0000, op_ff};
         sel_flags: nxt_prdata = {27'h000_0000, ~idle, flags_ff};
         sel_res0: nxt_prdata = {16'h0000, res_ff.w0};
         sel_res1: nxt_prdata = {16'h0000, res_ff.w1};
         sel_res2: nxt_prdata = {16'h0000, res_ff.w2};
         sel_res3: nxt_prdata = {16'h0000, res_ff.w3};
         sel_istat: nxt_prdata = {29'h0000_0000, irq_stat_ff};
         sel_imask: nxt_prdata = {29'h0000_0000, irq_mask_ff};
         default: nxt_prdata = RST_RDATA;
      endcase
   end

   // apb handshake: one wait state, answer from flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= RST_RDATA;
      end
      else if (ce)
      begin
         pready_ff <= access;
         pslverr_ff <= access & ~mapped;
         if (access & ~pwrite)
         begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   // operand registers and command latch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_lo_ff <= RST_WORD;
         a_hi_ff <= RST_WORD;
         b_lo_ff <= RST_WORD;
         b_hi_ff <= RST_WORD;
         op_ff <= RST_OP;
      end
      else if (ce)
      begin
         if (wr_en & sel_a_lo) a_lo_ff <= pwdata[15:0];
         if (wr_en & sel_a_hi) a_hi_ff <= pwdata[15:0];
         if (wr_en & sel_b_lo) b_lo_ff <= pwdata[15:0];
         if (wr_en & sel_b_hi) b_hi_ff <= pwdata[15:0];
         if (cmd_take) op_ff <= cmd_code;
      end
   end

   // execution state, results and flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= ST_IDLE;
         res_ff <= '0;
         flags_ff <= RST_FLAGS;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         res_ff <= nxt_res;
         flags_ff <= nxt_flags;
      end
   end

   // interrupt status, mask and output level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_ff <= RST_IRQ;
         irq_mask_ff <= RST_IRQ;
         irq_ff <= 1'b0;
      end
      else if (ce)
      begin
         irq_stat_ff <= nxt_irq_stat;
         if (wr_en & sel_imask) irq_mask_ff <= pwdata[IRQ_W-1:0];
         irq_ff <= irq_pending;
      end
   end

   // outputs straight from flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;

endmodule

// File: rtl/alu_pkg.sv
// Purpose: shared constants and types for the decimal subtract and multiply unit
// Assumes: 16-bit words, APB register map on 32-bit aligned words
// Notes: operation codes follow the controller's function code numbers
package alu_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_A_LO = 8'h00;
   localparam logic [7:0] OFS_A_HI = 8'h04;
   localparam logic [7:0] OFS_B_LO = 8'h08;
   localparam logic [7:0] OFS_B_HI = 8'h0C;
   localparam logic [7:0] OFS_CMD = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;
   localparam logic [7:0] OFS_RES0 = 8'h18;
   localparam logic [7:0] OFS_RES1 = 8'h1C;
   localparam logic [7:0] OFS_RES2 = 8'h20;
   localparam logic [7:0] OFS_RES3 = 8'h24;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;

   // operation codes written to the command register
   localparam logic [11:0] OP_SUB_WORD = 12'h1A0;
   localparam logic [11:0] OP_SUB_DOUBLE = 12'h1A1;
   localparam logic [11:0] OP_MUL_S_WORD = 12'h1A4;
   localparam logic [11:0] OP_MUL_S_DOUBLE = 12'h1A5;
   localparam logic [11:0] OP_MUL_U_WORD = 12'h1A6;
   localparam logic [11:0] OP_MUL_U_DOUBLE = 12'h1A7;
   localparam logic [11:0] OP_CARRY_CLEAR = 12'h029;

   // flag register bit positions
   localparam int FLG_FAULT = 0;
   localparam int FLG_ZERO = 1;
   localparam int FLG_BORROW = 2;
   localparam int FLG_NEG = 3;
   localparam int FLG_BUSY = 4;

   // interrupt status and mask bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_REJECT = 2;
   localparam int IRQ_W = 3;

   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [11:0] RST_OP = 12'h000;
   localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;

   // decimal digit limit
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [4:0] BCD_BASE = 5'h0A;

   typedef struct packed
   {
      logic negative;
      logic borrow;
      logic zero;
      logic fault;
   } flags_t;

   localparam flags_t RST_FLAGS = '{negative: 1'b0, borrow: 1'b0, zero: 1'b0, fault: 1'b0};

   // four result words, w0 at the lowest address
   typedef struct packed
   {
      logic [15:0] w3;
      logic [15:0] w2;
      logic [15:0] w1;
      logic [15:0] w0;
   } quad_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } state_t;

endpackage

// File: rtl/bcd_sub_chain.sv
// Purpose: eight-digit decimal subtractor with borrow in and digit checks
// Assumes: minuend and subtrahend packed four bits per digit, digit 0 lowest
// Notes: purely combinational; caller registers the outputs
`timescale 1ns/1ps
module bcd_sub_chain
   import alu_pkg::*;
(
   // operands
   input wire logic [31:0] minuend,
   input wire logic [31:0] subtrahend,
   input wire logic borrow_in,
   // results
   output logic [31:0] diff,
   output logic borrow_word,
   output logic borrow_double,
   output logic bad_word,
   output logic bad_double
);

   // a digit above nine is not decimal
   function automatic logic digit_bad(input logic [3:0] d);
      digit_bad = (d > BCD_MAX);
   endfunction

   // digit-serial subtract; a final borrow leaves the ten's complement in diff
   always_comb
   begin
      logic br;
      logic [4:0] t;
      logic [3:0] a;
      logic [3:0] b;
      a = 4'h0;
      b = 4'h0;
      br = borrow_in;
      t = 5'h00;
      diff = 32'h0000_0000;
      borrow_word = 1'b0;
      bad_word = 1'b0;
      bad_double = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         a = minuend[4*i +: 4];
         b = subtrahend[4*i +: 4];
         t = {1'b0, a} + BCD_BASE - {1'b0, b} - {4'h0, br};
         if (t >= BCD_BASE)
         begin
            diff[4*i +: 4] = 4'(t - BCD_BASE);
            br = 1'b0;
         end
         else
         begin
            diff[4*i +: 4] = t[3:0];
            br = 1'b1;
         end
         bad_double = bad_double | digit_bad(a) | digit_bad(b);
         if (i == 3)
         begin
            borrow_word = br;
            bad_word = bad_double;
         end
      end
      borrow_double = br;
   end

endmodule

// File: tb/alu_chk.sv
// Purpose: bus-side checks for the subtract and multiply unit
// Assumes: aligned addresses, ce held high
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module alu_chk
   import alu_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // interrupt
   input wire logic irq
);
   // address classes of a finishing access
   wire rd_done = pready && !pwrite;
   wire hole = paddr > OFS_IRQ_MASK;
   wire dword = paddr < OFS_CMD || (paddr >= OFS_RES0 && paddr <= OFS_RES3);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_wait_one: assert property (psel && penable && !pready && ce |=> pready)
      else $error("pready late");
   chk_ready_cause: assert property (pready |-> psel && $past(penable))
      else $error("pready without access");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   chk_hole_err: assert property (pready && hole |-> pslverr)
      else $error("unmapped access accepted");
   chk_map_ok: assert property (pready && !hole && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   chk_hole_zero: assert property (rd_done && hole |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_word_high: assert property (rd_done && dword |-> prdata[31:16] == 16'h0)
      else $error("word upper half set");
   chk_busy_idle: assert property (rd_done && paddr == OFS_FLAGS |-> prdata[31:4] == 28'h0)
      else $error("flags read shows busy");
endmodule
bind decimal_subtract_and_multiply_unit alu_chk u_chk (.pclk(pclk), .presetn(presetn),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// File: tb/seq_model.sv
// Purpose: apb model of the instruction sequencer
// Assumes: one transfer at a time
// Notes: released address and data lines are inverted to expose stale use
`timescale 1ns/1ps
module seq_model
(
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // setup cycle, then access held until pready is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic err, output logic hung);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (!pready && n < 16);
      r = prdata;
      err = pslverr;
      hung = !pready;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// File: tb/decimal_subtract_and_multiply_unit_tb_top.sv
// Purpose: self-checking bench for the subtract and multiply unit
// Assumes: ce held high, aligned accesses
// Notes: subtract and multiply corner cases then seeded random operands
`timescale 1ns/1ps
module decimal_subtract_and_multiply_unit_tb_top
   import alu_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, irq, er, hg, cy, ng;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] op;
   logic [11:0] ops [6] = '{OP_SUB_WORD, OP_SUB_DOUBLE, OP_MUL_S_WORD, OP_MUL_S_DOUBLE,
      OP_MUL_U_WORD, OP_MUL_U_DOUBLE};
   int n_errors = 0;
   int samples_checked = 0;

   // 8 ns clock
   always #4 pclk = ~pclk;

   decimal_subtract_and_multiply_unit dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   seq_model u_seq (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic same(input logic [63:0] got, input logic [63:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_seq.xfer(w, a, d, rd, er, hg);
      if (hg)
      begin
         n_errors++;
         $display("BAD %0t bus hang", $time);
         give_verdict();
      end
   endtask

   // packed decimal to integer and back
   function automatic longint dec(input logic [31:0] v);
      longint r = 0;
      for (int i = 7; i >= 0; i--)
         r = r * 10 + v[4*i +: 4];
      return r;
   endfunction

   function automatic logic [31:0] enc(input longint v);
      logic [31:0] r;
      for (int i = 0; i < 8; i++)
      begin
         r[4*i +: 4] = 4'(v % 10);
         v = v / 10;
      end
      return r;
   endfunction

   function automatic logic bad(input logic [31:0] v);
      logic b = 1'b0;
      for (int i = 0; i < 8; i++)
         b |= v[4*i +: 4] > BCD_MAX;
      return b;
   endfunction

   function automatic logic [31:0] rbcd();
      logic [31:0] r;
      for (int i = 0; i < 8; i++)
         r[4*i +: 4] = 4'($urandom % 10);
      return r;
   endfunction

   task automatic clr();
      bus(1'b1, OFS_CMD, {20'h0, OP_CARRY_CLEAR});
      bus(1'b0, OFS_FLAGS, 32'h0);
      cy = 1'b0;
      same(64'(rd[FLG_BORROW]), 64'h0, "borrow after clear");
   endtask

   // load operands, issue a command, read back and compare
   task automatic op_chk(input logic [11:0] op, input logic [31:0] a, input logic [31:0] b);
      logic [63:0] res, x, m;
      logic [3:0] fm;
      logic signed [31:0] p;
      longint d;
      logic dbl, f;
      bus(1'b1, OFS_A_LO, {16'h0, a[15:0]});
      bus(1'b1, OFS_A_HI, {16'h0, a[31:16]});
      bus(1'b1, OFS_B_LO, {16'h0, b[15:0]});
      bus(1'b1, OFS_B_HI, {16'h0, b[31:16]});
      bus(1'b1, OFS_CMD, {20'h0, op});
      dbl = op inside {OP_SUB_DOUBLE, OP_MUL_S_DOUBLE, OP_MUL_U_DOUBLE};
      if (!dbl)
      begin
         a[31:16] = 16'h0;
         b[31:16] = 16'h0;
      end
      m = 64'hFFFF_FFFF_FFFF_FFFF;
      f = 1'b0;
      if (op == OP_SUB_WORD || op == OP_SUB_DOUBLE)
      begin
         d = dec(a) - dec(b) - cy;
         cy = d < 0;
         x = enc(d < 0 ? d + (dbl ? 100000000 : 10000) : d);
         f = bad(a) | bad(b);
         if (f)
            m = 64'h0;
      end
      else
      begin
         p = $signed(a[15:0]) * $signed(b[15:0]);
         x = a * b;
         if (op == OP_MUL_S_WORD)
            x = {32'h0, p};
         if (op == OP_MUL_S_DOUBLE)
            x = $signed(a) * $signed(b);
         if (!dbl)
            m = 64'hFFFF_FFFF;
         ng = dbl ? x[63] : x[31];
      end
      fm = f ? 4'h1 : 4'hF;
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b0, OFS_RES0 + 8'(4 * i), 32'h0);
         res[16*i +: 16] = rd[15:0];
      end
      bus(1'b0, OFS_FLAGS, 32'h0);
      same(res & m, x & m, "result");
      same(64'(rd[3:0] & fm), 64'({ng, cy, (x & m) == 64'h0, f} & fm), "flags");
   endtask

   initial
   begin
      void'($urandom(16558));
      ng = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         bus(1'b0, 8'(4 * i), 32'h0);
         same(rd, 64'h0, "reset value");
      end
      $display("test reset done");
      bus(1'b1, OFS_FLAGS, 32'h4);
      cy = 1'b1;
      op_chk(OP_SUB_WORD, 32'h0, 32'h0);
      clr();
      op_chk(OP_SUB_WORD, 32'hABCD_0000, 32'h7556);
      op_chk(OP_SUB_WORD, 32'h5000, 32'h4999);
      op_chk(OP_SUB_DOUBLE, 32'h0958_3960, 32'h1707_2641);
      op_chk(OP_SUB_WORD, 32'h12A4, 32'h1);
      op_chk(OP_SUB_DOUBLE, 32'h0, 32'hF000_0000);
      clr();
      op_chk(OP_MUL_S_WORD, 32'h8000, 32'h8000);
      op_chk(OP_MUL_S_WORD, 32'hFFFF, 32'h1);
      op_chk(OP_MUL_S_DOUBLE, 32'h8000_0000, 32'h7FFF_FFFF);
      op_chk(OP_MUL_U_WORD, 32'hFFFF, 32'hFFFF);
      op_chk(OP_MUL_U_DOUBLE, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      op_chk(OP_MUL_U_DOUBLE, 32'h0, 32'h1234_5678);
      $display("test corners done");
      for (int k = 0; k < 60; k++)
      begin
         op = ops[$urandom % 6];
         if (op == OP_SUB_WORD || op == OP_SUB_DOUBLE)
            op_chk(op, rbcd(), rbcd());
         else
            op_chk(op, $urandom, $urandom);
      end
      $display("test random done");
      bus(1'b1, OFS_IRQ_STAT, 32'h7);
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      same(64'(irq), 64'h0, "irq idle");
      op_chk(OP_MUL_U_WORD, 32'h3, 32'h5);
      same(64'(irq), 64'h1, "irq on done");
      bus(1'b1, OFS_CMD, 32'h123);
      bus(1'b1, OFS_IRQ_STAT, 32'h1);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      same(rd, 64'h4, "refused status");
      same(64'(irq), 64'h0, "irq masked");
      bus(1'b1, OFS_IRQ_MASK, 32'h4);
      bus(1'b0, OFS_IRQ_MASK, 32'h0);
      same(64'(irq), 64'h1, "irq on refusal");
      bus(1'b0, 8'h30, 32'h0);
      same({er, rd}, {1'b1, 32'h0}, "unmapped read");
      $display("test irq done");
      // second reset in mid-run clears flags, mask and the interrupt
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      same(64'(irq), 64'h0, "irq after reset");
      bus(1'b0, OFS_FLAGS, 32'h0);
      same(rd, 64'h0, "flags after reset");
      bus(1'b0, OFS_IRQ_MASK, 32'h0);
      same(rd, 64'h0, "mask after reset");
      $display("test reset again done");
      give_verdict();
   end
endmodule
